/* File: dv/pbc_mgr.sv */
// Management entity model issuing one-cycle register accesses
`timescale 1ns/1ps
module pbc_mgr (
	// Clock
	input  wire logic              clk_in,
	// Requests to the register
	output pbc_pkg::pbc_mgmt_req_t req_out
);
	initial req_out = '0;

	task automatic acc(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_in);
		req_out.wr = w;
		req_out.rd = r;
		req_out.addr = a;
		req_out.wdata = d & ~(16'h0001 << pbc_pkg::BIT_ISOLATE);
		@(negedge clk_in);
		req_out.wr = 1'h0;
		req_out.rd = 1'h0;
		// Released lines show the inverse of the last value
		req_out.addr = ~req_out.addr;
		req_out.wdata = ~req_out.wdata;
	endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the basic control register
`timescale 1ns/1ps
module testbench;
	logic                   clk = 1'h0;
	logic                   srst = 1'h1;
	pbc_pkg::pbc_mgmt_req_t req;
	pbc_pkg::pbc_neg_t      neg = '0;
	logic                   tx_en = 1'h0, col_i = 1'h0, crs_i = 1'h0, rxdv_i = 1'h0;
	logic [15:0]            rdata;
	logic                   n_en, n_rs, pd, iso, dup, spd, col, crs, rxdv;
	logic                   an = 1'h1, pd_m = 1'h0, rs = 1'h0, dw = 1'h1, sw = 1'h1, ct = 1'h0;
	logic [15:0]            expq [$];
	logic                   pend = 1'h0;
	logic [31:0]            seed = 32'h0000_64f7;
	int                     err_total = 0;
	int                     checks = 0;

	always #10 clk = ~clk;

	pbc_mgr MGR (.clk_in(clk), .req_out(req));
	pbc_ctrl DUT (.clk_in(clk), .srst_in(srst), .mgmt_in(req), .rdata_out(rdata), .neg_in(neg),
		.neg_enable_out(n_en), .neg_restart_out(n_rs), .power_down_out(pd), .isolate_out(iso),
		.duplex_out(dup), .speed_out(spd), .mii_tx_en_in(tx_en), .mii_col_in(col_i),
		.mii_crs_in(crs_i), .mii_rx_dv_in(rxdv_i), .mii_col_out(col), .mii_crs_out(crs),
		.mii_rx_dv_out(rxdv));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [15:0] expv(input logic [4:0] a);
		expv = {2'h0, an ? neg.speed : sw, an, pd_m, 1'h0, rs, an ? neg.duplex : dw, ct, 7'h00};
		if (a != 5'h00)
			expv = 16'h0000;
	endfunction

	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] d);
		MGR.acc(1'h1, 1'h0, 5'h00, d);
		rs = d[12] & (d[9] | rs);
		{an, pd_m, ct, dw, sw} = {d[12], d[11], d[7], d[8], d[13]};
	endtask

	task automatic rd(input logic [4:0] a);
		expq.push_back(expv(a));
		MGR.acc(1'h0, 1'h1, a, 16'h0000);
	endtask

	task automatic results();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Read results land on the read edge and are checked at the next falling edge
	always @(posedge clk) pend <= req.rd;
	always @(negedge clk)
		if (pend)
			chk("rdata", rdata, expq.pop_front());

	initial
	begin
		repeat (2000) @(posedge clk);
		err_total++;
		results();
	end

	initial
	begin
		repeat (4) @(negedge clk);
		srst = 1'h0;
		rd(5'h00);
		rd(5'h03);
		wr(16'hc47f);
		rd(5'h00);
		chk("duplex", dup, 1'h0);
		chk("isolate", iso, 1'h0);
		wr(16'h2300);
		rd(5'h00);
		chk("restart", n_rs, 1'h0);
		repeat (4)
		begin
			neg = 3'(rnd());
			neg.started = 1'h0;
			wr(16'h1280);
			chk("restart", n_rs, 1'h1);
			chk("duplex", dup, neg.duplex);
			chk("speed", spd, neg.speed);
			wr(16'h1080);
			rd(5'h00);
			neg.started = 1'h1;
			@(negedge clk);
			neg.started = 1'h0;
			rs = 1'h0;
			rd(5'h00);
			@(negedge clk);
			{tx_en, col_i} = {seed[0], ~seed[0]};
			#1 chk("col", col, tx_en);
		end
		wr(16'h1880);
		{tx_en, col_i, crs_i, rxdv_i} = 4'hf;
		#1 chk("mii", {col, crs, rxdv}, 3'h0);
		chk("neg_en", {pd, n_en}, 2'h2);
		rd(5'h00);
		wr(16'h1000);
		chk("neg_en", {n_en, crs}, 2'h3);
		{tx_en, col_i} = 2'h2;
		#1 chk("col", col, 1'h0);
		repeat (3) @(negedge clk);
		results();
	end
endmodule

/* File: rtl/pbc_ctrl.sv */
// PHY basic control register: negotiation, power down, duplex, collision test
//
// How it works
// - Negotiation enable selects negotiated duplex and speed
// - Power-down bit idles PHY; management still works
// - MII outputs held quiet during power down
// - Restart bit reads one until negotiation starts
// - Restart ignored while negotiation disabled
// - Clearing restart does not stop negotiation
// - Written duplex applies only without negotiation
// - Duplex reads negotiated value when enabled
// - Collision test echoes TX_EN onto COL
// - Low seven bits read zero, writes dropped
// - Speed reads negotiated value when enabled
`timescale 1ns/1ps
module pbc_ctrl (
	// Clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   srst_in,
	// Management access
	input  wire pbc_pkg::pbc_mgmt_req_t mgmt_in,
	output logic [15:0]                 rdata_out,
	// Negotiation engine
	input  wire pbc_pkg::pbc_neg_t      neg_in,
	output logic                        neg_enable_out,
	output logic                        neg_restart_out,
	// Effective mode to datapath
	output logic                        power_down_out,
	output logic                        isolate_out,
	output logic                        duplex_out,
	output logic                        speed_out,
	// Internal MII
	input  wire logic                   mii_tx_en_in,
	input  wire logic                   mii_col_in,
	input  wire logic                   mii_crs_in,
	input  wire logic                   mii_rx_dv_in,
	output logic                        mii_col_out,
	output logic                        mii_crs_out,
	output logic                        mii_rx_dv_out
);
	pbc_pkg::pbc_state_t s_q;
	pbc_pkg::pbc_state_t s_d;
	logic                hit;
	logic                eff_duplex;
	logic                eff_speed;

	assign hit = (mgmt_in.addr == pbc_pkg::ADDR_CTRL);
	assign eff_duplex = s_q.anen ? neg_in.duplex : s_q.duplex;
	assign eff_speed  = s_q.anen ? neg_in.speed : s_q.speed;

	always_comb
	begin
		s_d = s_q;
		// Self-clear once the engine reports start; write of 1 with ANEN set wins same cycle
		if (s_q.restart && neg_in.started)
			s_d.restart = 1'b0;
		if (mgmt_in.wr && hit)
		begin
			s_d.anen    = mgmt_in.wdata[pbc_pkg::BIT_ANEN];
			s_d.pdown   = mgmt_in.wdata[pbc_pkg::BIT_PDOWN];
			s_d.isolate = mgmt_in.wdata[pbc_pkg::BIT_ISOLATE];
			s_d.duplex  = mgmt_in.wdata[pbc_pkg::BIT_DUPLEX];
			s_d.coltest = mgmt_in.wdata[pbc_pkg::BIT_COLTEST];
			s_d.speed   = mgmt_in.wdata[pbc_pkg::BIT_SPEED];
			// Restart only latched with negotiation enabled; clearing it is harmless
			if (mgmt_in.wdata[pbc_pkg::BIT_RESTART] && mgmt_in.wdata[pbc_pkg::BIT_ANEN])
				s_d.restart = 1'b1;
			else if (!mgmt_in.wdata[pbc_pkg::BIT_ANEN])
				s_d.restart = 1'b0;
		end
		if (mgmt_in.rd)
		begin
			s_d.rdata = 16'h0000;
			if (hit)
			begin
				s_d.rdata[pbc_pkg::BIT_SPEED]   = eff_speed;
				s_d.rdata[pbc_pkg::BIT_ANEN]    = s_q.anen;
				s_d.rdata[pbc_pkg::BIT_PDOWN]   = s_q.pdown;
				s_d.rdata[pbc_pkg::BIT_ISOLATE] = s_q.isolate;
				s_d.rdata[pbc_pkg::BIT_RESTART] = s_q.restart;
				s_d.rdata[pbc_pkg::BIT_DUPLEX]  = eff_duplex;
				s_d.rdata[pbc_pkg::BIT_COLTEST] = s_q.coltest;
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			s_q.anen    <= pbc_pkg::RST_ANEN;
			s_q.pdown   <= pbc_pkg::RST_PDOWN;
			s_q.isolate <= pbc_pkg::RST_ISOLATE;
			s_q.restart <= pbc_pkg::RST_RESTART;
			s_q.duplex  <= pbc_pkg::RST_DUPLEX;
			s_q.coltest <= pbc_pkg::RST_COLTEST;
			s_q.speed   <= pbc_pkg::RST_SPEED;
			s_q.rdata   <= pbc_pkg::RST_RDATA;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign rdata_out       = s_q.rdata;
	assign neg_enable_out  = s_q.anen && !s_q.pdown;
	// Engine sees the held request; a later clear from software does not abort it
	assign neg_restart_out = s_q.restart && s_q.anen;
	assign power_down_out  = s_q.pdown;
	assign isolate_out     = s_q.isolate;
	assign duplex_out      = eff_duplex;
	assign speed_out       = eff_speed;
	// Quiet MII while powered down, collision test echoes transmit enable
	assign mii_col_out   = !s_q.pdown && (s_q.coltest ? mii_tx_en_in : mii_col_in);
	assign mii_crs_out   = !s_q.pdown && mii_crs_in;
	assign mii_rx_dv_out = !s_q.pdown && mii_rx_dv_in;

	property p_coltest;
		@(posedge clk_in) disable iff (srst_in)
		(s_q.coltest && !s_q.pdown && mii_tx_en_in) |-> mii_col_out;
	endproperty
	a_coltest: assert property (p_coltest) else $error("collision test not echoed");

	property p_quiet;
		@(posedge clk_in) disable iff (srst_in)
		s_q.pdown |-> !(mii_col_out || mii_crs_out || mii_rx_dv_out);
	endproperty
	a_quiet: assert property (p_quiet) else $error("MII active in power down");

	property p_reserved;
		@(posedge clk_in) disable iff (srst_in)
		rdata_out[6:0] == 7'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

	sequence s_restart_wr;
		mgmt_in.wr && hit && mgmt_in.wdata[pbc_pkg::BIT_RESTART] && mgmt_in.wdata[pbc_pkg::BIT_ANEN];
	endsequence
	property p_restart_set;
		@(posedge clk_in) disable iff (srst_in)
		s_restart_wr |=> s_q.restart;
	endproperty
	a_restart_set: assert property (p_restart_set) else $error("restart not latched");

	property p_restart_hold;
		@(posedge clk_in) disable iff (srst_in)
		(s_q.restart && !neg_in.started && !(mgmt_in.wr && hit)) |=> s_q.restart;
	endproperty
	a_restart_hold: assert property (p_restart_hold) else $error("restart cleared early");

	property p_restart_off;
		@(posedge clk_in) disable iff (srst_in)
		!s_q.anen |-> !(s_q.restart || neg_restart_out);
	endproperty
	a_restart_off: assert property (p_restart_off) else $error("restart acted while disabled");

	property p_duplex_read;
		@(posedge clk_in) disable iff (srst_in)
		(mgmt_in.rd && hit && s_q.anen) |=> rdata_out[pbc_pkg::BIT_DUPLEX] == $past(neg_in.duplex);
	endproperty
	a_duplex_read: assert property (p_duplex_read) else $error("duplex read not negotiated");

	property p_duplex_forced;
		@(posedge clk_in) disable iff (srst_in)
		!s_q.anen |-> duplex_out == s_q.duplex;
	endproperty
	a_duplex_forced: assert property (p_duplex_forced) else $error("forced duplex ignored");

	property p_speed_read;
		@(posedge clk_in) disable iff (srst_in)
		(mgmt_in.rd && hit && s_q.anen) |=> rdata_out[pbc_pkg::BIT_SPEED] == $past(neg_in.speed);
	endproperty
	a_speed_read: assert property (p_speed_read) else $error("speed read not negotiated");

	property p_pdown_write;
		@(posedge clk_in) disable iff (srst_in)
		(mgmt_in.wr && hit) |=> power_down_out == $past(mgmt_in.wdata[pbc_pkg::BIT_PDOWN]);
	endproperty
	a_pdown_write: assert property (p_pdown_write) else $error("power down not taken");

	property p_reset_vals;
		@(posedge clk_in)
		srst_in |=> (s_q.anen && s_q.duplex && s_q.speed && !s_q.pdown
			&& !s_q.isolate && !s_q.restart && !s_q.coltest && s_q.rdata == pbc_pkg::RST_RDATA);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

	// Request shapes shared by the checks below
	sequence s_ctrl_wr;
		mgmt_in.wr && hit;
	endsequence
	sequence s_miss_rd;
		mgmt_in.rd && !hit;
	endsequence
	sequence s_anen_off_wr;
		mgmt_in.wr && hit && !mgmt_in.wdata[pbc_pkg::BIT_ANEN];
	endsequence
	sequence s_restart_done;
		s_q.restart && neg_in.started && !(mgmt_in.wr && hit && mgmt_in.wdata[pbc_pkg::BIT_RESTART]);
	endsequence
	sequence s_sw_clear;
		s_q.restart && !neg_in.started && mgmt_in.wr && hit
			&& mgmt_in.wdata[pbc_pkg::BIT_ANEN] && !mgmt_in.wdata[pbc_pkg::BIT_RESTART];
	endsequence

	property p_anen_write;
		@(posedge clk_in) disable iff (srst_in)
		s_ctrl_wr |=> s_q.anen == $past(mgmt_in.wdata[pbc_pkg::BIT_ANEN]);
	endproperty
	a_anen_write: assert property (p_anen_write) else $error("negotiation enable not taken");

	property p_neg_off;
		@(posedge clk_in) disable iff (srst_in)
		!s_q.anen |-> !neg_enable_out;
	endproperty
	a_neg_off: assert property (p_neg_off) else $error("negotiation running while disabled");

	property p_pdown_idle;
		@(posedge clk_in) disable iff (srst_in)
		s_q.pdown |-> !neg_enable_out;
	endproperty
	a_pdown_idle: assert property (p_pdown_idle) else $error("negotiation running in power down");

	property p_pdown_read;
		@(posedge clk_in) disable iff (srst_in)
		(mgmt_in.rd && hit && s_q.pdown) |=> rdata_out[pbc_pkg::BIT_PDOWN];
	endproperty
	a_pdown_read: assert property (p_pdown_read) else $error("no read answer in power down");

	property p_rdata_hold;
		@(posedge clk_in) disable iff (srst_in)
		!mgmt_in.rd |=> $stable(rdata_out);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

	property p_restart_pulse;
		@(posedge clk_in) disable iff (srst_in)
		s_restart_wr |=> neg_restart_out;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse) else $error("restart not passed to engine");

	property p_restart_clear;
		@(posedge clk_in) disable iff (srst_in)
		s_restart_done |=> !s_q.restart;
	endproperty
	a_restart_clear: assert property (p_restart_clear) else $error("restart did not self clear");

	property p_restart_read;
		@(posedge clk_in) disable iff (srst_in)
		(mgmt_in.rd && hit && s_q.restart) |=> rdata_out[pbc_pkg::BIT_RESTART];
	endproperty
	a_restart_read: assert property (p_restart_read) else $error("pending restart read as zero");

	property p_restart_drop;
		@(posedge clk_in) disable iff (srst_in)
		s_anen_off_wr |=> !s_q.restart && !neg_restart_out;
	endproperty
	a_restart_drop: assert property (p_restart_drop) else $error("restart kept with negotiation off");

	property p_restart_keep;
		@(posedge clk_in) disable iff (srst_in)
		s_sw_clear |=> s_q.restart && neg_restart_out;
	endproperty
	a_restart_keep: assert property (p_restart_keep) else $error("software clear aborted restart");

	property p_duplex_write;
		@(posedge clk_in) disable iff (srst_in)
		s_ctrl_wr |=> s_q.duplex == $past(mgmt_in.wdata[pbc_pkg::BIT_DUPLEX]);
	endproperty
	a_duplex_write: assert property (p_duplex_write) else $error("duplex write not stored");

	property p_duplex_neg;
		@(posedge clk_in) disable iff (srst_in)
		s_q.anen |-> duplex_out == neg_in.duplex;
	endproperty
	a_duplex_neg: assert property (p_duplex_neg) else $error("duplex not negotiated");

	property p_col_normal;
		@(posedge clk_in) disable iff (srst_in)
		(!s_q.coltest && !s_q.pdown) |-> mii_col_out == mii_col_in;
	endproperty
	a_col_normal: assert property (p_col_normal) else $error("collision path altered");

	property p_coltest_write;
		@(posedge clk_in) disable iff (srst_in)
		s_ctrl_wr |=> s_q.coltest == $past(mgmt_in.wdata[pbc_pkg::BIT_COLTEST]);
	endproperty
	a_coltest_write: assert property (p_coltest_write) else $error("collision test write not stored");

	property p_miss_read;
		@(posedge clk_in) disable iff (srst_in)
		s_miss_rd |=> rdata_out == 16'h0000;
	endproperty
	a_miss_read: assert property (p_miss_read) else $error("other address read nonzero");

	property p_speed_forced;
		@(posedge clk_in) disable iff (srst_in)
		!s_q.anen |-> speed_out == s_q.speed;
	endproperty
	a_speed_forced: assert property (p_speed_forced) else $error("forced speed ignored");

	property p_speed_neg;
		@(posedge clk_in) disable iff (srst_in)
		s_q.anen |-> speed_out == neg_in.speed;
	endproperty
	a_speed_neg: assert property (p_speed_neg) else $error("speed not negotiated");
endmodule

/* File: rtl/pbc_pkg.sv */
// Package for the PHY basic control register block
package pbc_pkg;
	// Register address inside the management register space
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	// Bit positions
	localparam int BIT_RESET   = 15;
	localparam int BIT_LOOP    = 14;
	localparam int BIT_SPEED   = 13;
	localparam int BIT_ANEN    = 12;
	localparam int BIT_PDOWN   = 11;
	localparam int BIT_ISOLATE = 10;
	localparam int BIT_RESTART = 9;
	localparam int BIT_DUPLEX  = 8;
	localparam int BIT_COLTEST = 7;
	// Reset values
	localparam logic RST_ANEN    = 1'h1;
	localparam logic RST_PDOWN   = 1'h0;
	localparam logic RST_ISOLATE = 1'h0;
	localparam logic RST_RESTART = 1'h0;
	localparam logic RST_DUPLEX  = 1'h1;
	localparam logic RST_COLTEST = 1'h0;
	localparam logic RST_SPEED   = 1'h1;
	localparam logic [15:0] RST_RDATA = 16'h0000;

	typedef struct packed {
		logic anen;
		logic pdown;
		logic isolate;
		logic restart;
		logic duplex;
		logic coltest;
		logic speed;
		logic [15:0] rdata;
	} pbc_state_t;

	// Management access request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} pbc_mgmt_req_t;

	// Negotiation result from the datapath
	typedef struct packed {
		logic started;
		logic duplex;
		logic speed;
	} pbc_neg_t;
endpackage
